// file: hdl/link_stat_pkg.sv
// Purpose: Shared constants for the link status and packet counter bank
// Assumes: 16-bit indirect address port and 16-bit read-data port
// Notes: Bank register indices and port field positions
package link_stat_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned WIDE_W = 48;
    localparam int unsigned IDX_W = 5;
    // Indirect address port layout
    localparam int unsigned ADDR_READ_BIT = 15;
    localparam int unsigned ADDR_IDX_LSB = 0;
    // Bank register indices
    localparam logic [4:0] IDX_LINK_STATUS = 5'h01;
    localparam logic [4:0] IDX_GOOD_UPPER = 5'h02;
    localparam logic [4:0] IDX_GOOD_MIDDLE = 5'h03;
    localparam logic [4:0] IDX_GOOD_LOWER = 5'h04;
    localparam logic [4:0] IDX_CRC_UPPER = 5'h05;
    localparam logic [4:0] IDX_CRC_MIDDLE = 5'h06;
    localparam logic [4:0] IDX_CRC_LOWER = 5'h07;
    localparam logic [4:0] IDX_RXERR_DATA = 5'h08;
    // Status register bit positions
    localparam int unsigned BIT_SWAP_01 = 15;
    localparam int unsigned BIT_SWAP_23 = 14;
    localparam int unsigned BIT_SPEED_FALLBACK = 13;
    // Reset values
    localparam logic [15:0] RST_READ_DATA = 16'h0000;
    localparam logic [15:0] RST_STATUS = 16'h0000;
endpackage

// file: hdl/phy_link_status_and_packet_counters.sv
// Purpose: Read-only link status and receive statistics bank
// Assumes: Event strobes are one-cycle pulses; receive-control samples arrive with a strobe
// Notes: Reached only through the indirect address port and the read-data port
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Status bit 15 shows whether channels 0 and 1 resolved straight (0) or crossed (1).
// - Status bit 14 shows whether channels 2 and 3 resolved straight (0) or crossed (1).
// - Status bit 13 is set while the link was brought up by the speed fallback mechanism.
// - A 48-bit counter advances once per packet received without error.
// - The good packet counter is read as upper 47:32, middle 31:16 and lower 15:0 words.
// - Reading the good packet upper word clears that whole counter, other words do not.
// - A 48-bit counter advances once per error flagged by the receive checksum checker.
// - The checksum failure counter is read as upper 47:32, middle 31:16 and lower 15:0 words.
// - Reading the checksum failure upper word clears that whole counter.
// - A 16-bit counter advances on each rising edge of receive error while data valid is high, cleared on read.
// - Receive error and data valid are both derived from the single receive control line.
// - Writes to this bank have no effect.
module phy_link_status_and_packet_counters
    import link_stat_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Indirect register access
    input wire logic addr_port_wr_i,
    input wire logic [DATA_W-1:0] addr_port_data_i,
    output logic [DATA_W-1:0] read_data_o,
    // Link state from the line side
    input wire logic pair_swap_resolution_01_i,
    input wire logic pair_swap_resolution_23_i,
    input wire logic speed_fallback_link_i,
    // Receive events
    input wire logic good_rx_packet_i,
    input wire logic checksum_fail_i,
    // Receive control line, both edge samples of one receive clock
    input wire logic rx_control_line_valid_i,
    input wire logic rx_control_line_rise_i,
    input wire logic rx_control_line_fall_i
);
    logic [WIDE_W-1:0] good_rx_packet_count;
    logic [WIDE_W-1:0] checksum_fail_count;
    logic [DATA_W-1:0] rx_err_data_count;
    logic [DATA_W-1:0] status_r;
    logic rx_err_r;
    logic rx_err_now;
    logic rx_dv_now;
    logic rx_err_inc;
    logic read_req;
    logic [IDX_W-1:0] read_idx;
    logic clr_good;
    logic clr_crc;
    logic clr_rxerr;
    logic [DATA_W-1:0] read_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Status bits
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_r <= RST_STATUS;
        end else begin
            status_r <= '0;
            status_r[BIT_SWAP_01] <= pair_swap_resolution_01_i;
            status_r[BIT_SWAP_23] <= pair_swap_resolution_23_i;
            status_r[BIT_SPEED_FALLBACK] <= speed_fallback_link_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive control decoding: rise carries valid, fall carries valid xor error
    assign rx_dv_now = rx_control_line_rise_i;
    assign rx_err_now = rx_control_line_rise_i ^ rx_control_line_fall_i;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_err_r <= 1'b0;
        end else if (rx_control_line_valid_i) begin
            rx_err_r <= rx_err_now;
        end
    end

    assign rx_err_inc = rx_control_line_valid_i & rx_err_now & ~rx_err_r & rx_dv_now;

    ////////////////////////////////////////////////////////////////////////////
    // Indirect read decode; a write without the read flag is ignored
    assign read_req = addr_port_wr_i & addr_port_data_i[ADDR_READ_BIT];
    assign read_idx = addr_port_data_i[ADDR_IDX_LSB +: IDX_W];
    assign clr_good = read_req & (read_idx == IDX_GOOD_UPPER);
    assign clr_crc = read_req & (read_idx == IDX_CRC_UPPER);
    assign clr_rxerr = read_req & (read_idx == IDX_RXERR_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // Counters
    wrap_counter #(.WIDTH(WIDE_W)) u_good_cnt (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .inc_i(good_rx_packet_i),
        .clr_i(clr_good),
        .count_o(good_rx_packet_count)
    );

    wrap_counter #(.WIDTH(WIDE_W)) u_crc_cnt (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .inc_i(checksum_fail_i),
        .clr_i(clr_crc),
        .count_o(checksum_fail_count)
    );

    wrap_counter #(.WIDTH(DATA_W)) u_rxerr_cnt (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .inc_i(rx_err_inc),
        .clr_i(clr_rxerr),
        .count_o(rx_err_data_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; value taken before any clear takes effect
    always_comb begin
        unique case (read_idx)
            IDX_LINK_STATUS: read_sel = status_r;
            IDX_GOOD_UPPER: read_sel = good_rx_packet_count[47:32];
            IDX_GOOD_MIDDLE: read_sel = good_rx_packet_count[31:16];
            IDX_GOOD_LOWER: read_sel = good_rx_packet_count[15:0];
            IDX_CRC_UPPER: read_sel = checksum_fail_count[47:32];
            IDX_CRC_MIDDLE: read_sel = checksum_fail_count[31:16];
            IDX_CRC_LOWER: read_sel = checksum_fail_count[15:0];
            IDX_RXERR_DATA: read_sel = rx_err_data_count;
            default: read_sel = '0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            read_data_o <= RST_READ_DATA;
        end else if (read_req) begin
            read_data_o <= read_sel;
        end
    end
endmodule

// file: hdl/wrap_counter.sv
// Purpose: Wrapping event counter with clear
// Assumes: inc_i and clr_i synchronous to clk
// Notes: A count on the clearing cycle is kept
`timescale 1ns/100ps
module wrap_counter #(
    parameter int unsigned WIDTH = 16
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Control
    input wire logic inc_i,
    input wire logic clr_i,
    // Value
    output logic [WIDTH-1:0] count_o
);
    logic [WIDTH-1:0] count_nxt;

    always_comb begin
        if (clr_i) begin
            count_nxt = {{(WIDTH-1){1'b0}}, inc_i};
        end else begin
            count_nxt = count_o + {{(WIDTH-1){1'b0}}, inc_i};
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_o <= '0;
        end else begin
            count_o <= count_nxt;
        end
    end
endmodule

// file: verif/link_stat_asserts.sv
// Purpose: Port checker for the status and counter bank
// Assumes: Sees only the top ports
// Notes: Bound below
`timescale 1ns/100ps
module link_stat_asserts
    import link_stat_pkg::*;
(
    input wire logic sys_clk_i, rstn_i, addr_port_wr_i, good_rx_packet_i, checksum_fail_i,
    input wire logic [DATA_W-1:0] addr_port_data_i, read_data_o,
    input wire logic pair_swap_resolution_01_i, pair_swap_resolution_23_i, speed_fallback_link_i,
    input wire logic rx_control_line_valid_i, rx_control_line_rise_i, rx_control_line_fall_i
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic rd = addr_port_wr_i & addr_port_data_i[ADDR_READ_BIT];
    wire logic [4:0] ix = addr_port_data_i[4:0];
    wire logic [2:0] st = {pair_swap_resolution_01_i, pair_swap_resolution_23_i, speed_fallback_link_i};
    sequence s_rd(logic [4:0] i);
        rd && ix == i;
    endsequence
    AST_STATUS: assert property (s_rd(IDX_LINK_STATUS) ##0 ($past(rstn_i) && $stable(st)) |=>
        read_data_o == {$past(st), 13'h0000}) else $error("status word wrong");
    AST_HOLD: assert property (!rd |=> $stable(read_data_o)) else $error("read data moved");
    AST_UNMAPPED: assert property (rd && (ix == 5'h00 || ix > IDX_RXERR_DATA) |=> read_data_o == 16'h0000)
        else $error("unmapped read not zero");
    AST_GOOD_INC: assert property (s_rd(IDX_GOOD_LOWER) ##0 good_rx_packet_i ##1 s_rd(IDX_GOOD_LOWER) |=>
        read_data_o == $past(read_data_o) + 16'h0001) else $error("good count step wrong");
    AST_GOOD_CLR: assert property (s_rd(IDX_GOOD_UPPER) ##1 s_rd(IDX_GOOD_LOWER) |=>
        read_data_o == {15'h0000, $past(good_rx_packet_i, 2)}) else $error("good clear wrong");
    AST_CRC_INC: assert property (s_rd(IDX_CRC_LOWER) ##0 checksum_fail_i ##1 s_rd(IDX_CRC_LOWER) |=>
        read_data_o == $past(read_data_o) + 16'h0001) else $error("crc count step wrong");
    AST_CRC_CLR: assert property (s_rd(IDX_CRC_UPPER) ##1 s_rd(IDX_CRC_LOWER) |=>
        read_data_o == {15'h0000, $past(checksum_fail_i, 2)}) else $error("crc clear wrong");
    AST_RXERR_CLR: assert property (s_rd(IDX_RXERR_DATA) ##0 !rx_control_line_valid_i ##1
        s_rd(IDX_RXERR_DATA) |=> read_data_o == 16'h0000) else $error("rx error clear wrong");
endmodule
bind phy_link_status_and_packet_counters link_stat_asserts u_chk (.*);

// file: verif/phy_link_status_and_packet_counters_test.sv
// Purpose: Self-checking bench for the status and counter bank
// Assumes: Reads go through the indirect address port
// Notes: Mismatches name the register index
`timescale 1ns/100ps
module phy_link_status_and_packet_counters_test import link_stat_pkg::*;
;
    logic sys_clk_i = 1'b0, rstn_i = 1'b0, addr_port_wr_i = 1'b0, good_rx_packet_i = 1'b0, checksum_fail_i = 1'b0;
    logic [DATA_W-1:0] addr_port_data_i = 16'h0000, read_data_o;
    logic [2:0] lk = 3'h0;
    logic rx_control_line_valid_i, rx_control_line_rise_i, rx_control_line_fall_i;
    int bad_count = 0, samples_checked = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    phy_link_status_and_packet_counters dut (.*, .pair_swap_resolution_01_i(lk[2]),
        .pair_swap_resolution_23_i(lk[1]), .speed_fallback_link_i(lk[0]));
    rx_ctrl_partner mac (.sys_clk_i(sys_clk_i), .valid_o(rx_control_line_valid_i),
        .rise_o(rx_control_line_rise_i), .fall_o(rx_control_line_fall_i));
    task automatic chk(input logic [4:0] i, input logic [15:0] e);
        samples_checked++;
        if (read_data_o !== e) begin
            $display("wrong value idx %h expected %h seen %h", i, e, read_data_o);
            bad_count++;
        end
    endtask
    // Strobe stays high so reads run back to back
    task automatic rd(input logic [4:0] i, input logic [15:0] e);
        addr_port_data_i = {1'b1, 10'h000, i};
        addr_port_wr_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        chk(i, e);
    endtask
    task automatic idle(input int n);
        addr_port_wr_i = 1'b0;
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic t_status();
        for (int i = 1; i <= 8; i++) rd(5'(i), 16'h0000);
        lk = 3'h5;
        idle(2);
        rd(IDX_LINK_STATUS, 16'hA000);
        lk = 3'h2;
        idle(2);
        rd(IDX_LINK_STATUS, 16'h4000);
        rd(5'h09, 16'h0000);
        idle(1);
        $display("status test done");
    endtask
    task automatic t_good();
        good_rx_packet_i = 1'b1;
        idle(3);
        good_rx_packet_i = 1'b0;
        rd(IDX_GOOD_LOWER, 16'h0003);
        addr_port_data_i = 16'h0002;
        @(posedge sys_clk_i);
        #1;
        chk(5'h02, 16'h0003);
        rd(IDX_GOOD_LOWER, 16'h0003);
        rd(IDX_GOOD_UPPER, 16'h0000);
        rd(IDX_GOOD_LOWER, 16'h0000);
        good_rx_packet_i = 1'b1;
        idle(65536);
        rd(IDX_GOOD_LOWER, 16'h0000);
        good_rx_packet_i = 1'b0;
        rd(IDX_GOOD_LOWER, 16'h0001);
        rd(IDX_GOOD_MIDDLE, 16'h0001);
        rd(IDX_GOOD_UPPER, 16'h0000);
        rd(IDX_GOOD_LOWER, 16'h0000);
        idle(1);
        $display("good packet test done");
    endtask
    task automatic t_crc();
        checksum_fail_i = 1'b1;
        rd(IDX_CRC_LOWER, 16'h0000);
        checksum_fail_i = 1'b0;
        rd(IDX_CRC_LOWER, 16'h0001);
        rd(IDX_CRC_MIDDLE, 16'h0000);
        checksum_fail_i = 1'b1;
        rd(IDX_CRC_UPPER, 16'h0000);
        checksum_fail_i = 1'b0;
        rd(IDX_CRC_LOWER, 16'h0001);
        rd(IDX_CRC_UPPER, 16'h0000);
        rd(IDX_CRC_LOWER, 16'h0000);
        idle(1);
        mac.burst(3);
        rd(IDX_RXERR_DATA, 16'h0003);
        rd(IDX_RXERR_DATA, 16'h0000);
        idle(1);
        $display("error counter test done");
    endtask
    task automatic conclude();
        $display("checked %0d wrong %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_i);
        #1;
        rstn_i = 1'b1;
        t_status();
        t_good();
        t_crc();
        conclude();
    end
endmodule

// file: verif/rx_ctrl_partner.sv
// Purpose: Receive-control side of the MAC link
// Assumes: Called just after a rising edge
// Notes: Off-strobe samples carry inverted junk
`timescale 1ns/100ps
module rx_ctrl_partner (input wire logic sys_clk_i, output logic valid_o, rise_o, fall_o);
    initial {valid_o, rise_o, fall_o} = 3'h0;
    task automatic step(input logic [2:0] s);
        {valid_o, rise_o, fall_o} = s;
        @(posedge sys_clk_i);
        #1;
    endtask
    // Clean, error, held error per pass, then an idle error
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            step(3'h7);
            step(3'h6);
            step(3'h6);
        end
        step(3'h4);
        step(3'h5);
        step({1'b0, ~rise_o, ~fall_o});
    endtask
endmodule
